/* File: hw/bdp_pkg.sv */
`default_nettype none

package bdp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int BDP_PORT_W = 8;
    localparam int BDP_ADDR_W = 10;
    // register offsets are word indices; byte address is index * 4
    localparam logic [7:0] BDP_DATA_IDX = 8'h07;
    localparam logic [7:0] BDP_DIR_IDX = 8'h87;
    localparam logic [BDP_ADDR_W-1:0] BDP_DATA_ADDR = {BDP_DATA_IDX, 2'b00};
    localparam logic [BDP_ADDR_W-1:0] BDP_DIR_ADDR = {BDP_DIR_IDX, 2'b00};

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // all ones: every pin starts as an input
    localparam logic [BDP_PORT_W-1:0] BDP_DIR_RESET = 8'hff;
    // latch content after power-on is undefined; zero keeps sims clean
    localparam logic [BDP_PORT_W-1:0] BDP_LATCH_POR = 8'h00;
    localparam logic [31:0] BDP_RDATA_RESET = 32'h0000_0000;
    localparam int BDP_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // bus sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BDP_IDLE,
        BDP_SAMPLE,
        BDP_DONE
    } bdp_state_t;

endpackage

`default_nettype wire

/* File: hw/bdp_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module bdp_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // asynchronous levels in, clean levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("bdp_sync needs WIDTH of at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bdp_sync_state_t;

    bdp_sync_state_t s;
    bdp_sync_state_t next_s;

    // meta is read only by the second stage, never by logic
    always_comb begin
        next_s = s;
        next_s.meta = async_i;
        next_s.stable = s.meta;
    end

    // two flops, constants only under reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_o = s.stable;

endmodule

`default_nettype wire

/* File: hw/bdp_latch.sv */
`timescale 1ns/10ps
`default_nettype none

module bdp_latch #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] POR_VALUE = '0
) (
    // clock and power-on reset only
    input wire logic clock_i,
    input wire logic por_i,
    // load strobe and value
    input wire logic load_i,
    input wire logic [WIDTH-1:0] data_i,
    // latch content
    output logic [WIDTH-1:0] q_o
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("bdp_latch needs WIDTH of at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] value;
    } bdp_latch_state_t;

    bdp_latch_state_t s;
    bdp_latch_state_t next_s;

    // holds across ordinary resets; only power-on clears it
    always_comb begin
        next_s = s;
        if (load_i) begin
            next_s.value = data_i;
        end
    end

    always_ff @(posedge clock_i or posedge por_i) begin
        if (por_i) begin
            s <= POR_VALUE;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.value;

endmodule

`default_nettype wire

/* File: hw/bdp_port.sv */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R01 - eight latch bits, each pin own direction
// R02 - direction one puts pin driver off
// R03 - direction zero drives latch bit out
// R04 - data reads return pin levels, not latch
// R05 - data writes load latch, any direction
// R06 - writes sample pins, merge, then load
// R07 - register bit n maps to pin n
// R08 - data at 07h, latch kept over reset
// R09 - direction at 87h, resets to all ones
// R10 - pins synchronised before the read path

module bdp_port (
    // clock and resets
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic por_i,
    // avalon-mm slave
    input wire logic [bdp_pkg::BDP_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // port pins, split into in, out and enable
    input wire logic [bdp_pkg::BDP_PORT_W-1:0] pin_i,
    output logic [bdp_pkg::BDP_PORT_W-1:0] pin_o,
    output logic [bdp_pkg::BDP_PORT_W-1:0] pin_oe_o
);

    localparam int W = bdp_pkg::BDP_PORT_W;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        bdp_pkg::bdp_state_t state;
        logic wait_req;
        logic [31:0] rdata;
        logic [W-1:0] drive_en;
        logic [W-1:0] merged;
        logic load;
    } bdp_port_state_t;

    bdp_port_state_t s;
    bdp_port_state_t next_s;

    logic [W-1:0] pin_sync;
    logic [W-1:0] latch_q;
    logic sel_data;
    logic sel_dir;

    // ------------------------------------------------------------
    // pin input path
    // ------------------------------------------------------------
    // ttl buffer levels are async to us, so two flops first
    bdp_sync #(
        .WIDTH(W)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(pin_i),
        .sync_o(pin_sync)
    ); // see R10

    // ------------------------------------------------------------
    // output latch
    // ------------------------------------------------------------
    // only power-on clears it; other resets leave it as it was
    bdp_latch #(
        .WIDTH(W),
        .POR_VALUE(bdp_pkg::BDP_LATCH_POR)
    ) u_latch (
        .clock_i(clock_i),
        .por_i(por_i),
        .load_i(s.load),
        .data_i(s.merged),
        .q_o(latch_q)
    ); // see R01, R08

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // full compare: the low two address bits must be zero
    assign sel_data = (avs_address_i == bdp_pkg::BDP_DATA_ADDR); // see R08
    assign sel_dir = (avs_address_i == bdp_pkg::BDP_DIR_ADDR); // see R09

    // ------------------------------------------------------------
    // bus sequencer
    // ------------------------------------------------------------
    // waitrequest idles high and drops for exactly one cycle per access,
    // so the master's release always lands back in idle
    always_comb begin
        next_s = s;
        next_s.load = 1'b0;
        unique case (s.state)
            bdp_pkg::BDP_IDLE: begin
                if (avs_read_i) begin
                    next_s.rdata = 32'h0000_0000;
                    if (sel_data) begin
                        // live pin levels, bit n is pin n
                        next_s.rdata[W-1:0] = pin_sync; // see R04, R07
                    end else if (sel_dir) begin
                        next_s.rdata[W-1:0] = ~s.drive_en;
                    end
                    next_s.wait_req = 1'b0;
                    next_s.state = bdp_pkg::BDP_DONE;
                end else if (avs_write_i) begin
                    if (sel_data) begin
                        // first step of the read-modify-write
                        next_s.merged = pin_sync; // see R06
                        next_s.state = bdp_pkg::BDP_SAMPLE;
                    end else begin
                        if (sel_dir && avs_byteenable_i[0]) begin
                            next_s.drive_en = ~avs_writedata_i[W-1:0];
                        end
                        next_s.wait_req = 1'b0;
                        next_s.state = bdp_pkg::BDP_DONE;
                    end
                end
            end
            bdp_pkg::BDP_SAMPLE: begin
                // modify the sampled byte, then load; lane 0 off means the
                // latch is rewritten with the pin levels just sampled
                if (avs_byteenable_i[0]) begin
                    next_s.merged = avs_writedata_i[W-1:0]; // see R06
                end
                next_s.load = 1'b1; // see R05
                next_s.wait_req = 1'b0;
                next_s.state = bdp_pkg::BDP_DONE;
            end
            bdp_pkg::BDP_DONE: begin
                next_s.wait_req = 1'b1;
                next_s.state = bdp_pkg::BDP_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s.state <= bdp_pkg::BDP_IDLE;
            s.wait_req <= 1'b1;
            s.rdata <= bdp_pkg::BDP_RDATA_RESET;
            // rst_i turns all pins to inputs; por_i alone leaves the directions as they were
            s.drive_en <= ~bdp_pkg::BDP_DIR_RESET; // see R09, R02
            s.merged <= bdp_pkg::BDP_LATCH_POR;
            s.load <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // drive enable is stored inverted so the pin enable is a flop
    assign pin_oe_o = s.drive_en; // see R02, R03
    assign pin_o = latch_q; // see R03
    assign avs_readdata_o = s.rdata;
    assign avs_waitrequest_o = s.wait_req;

endmodule

`default_nettype wire

/* File: hw/bdp_unused_placeholder_removed.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: dv/bdp_port_properties.sv */
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------
// port checker
// ------------------------------------------------
module bdp_port_checker (
    // clock and resets
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic por_i,
    // bus
    input wire logic [bdp_pkg::BDP_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // pins
    input wire logic [bdp_pkg::BDP_PORT_W-1:0] pin_i,
    input wire logic [bdp_pkg::BDP_PORT_W-1:0] pin_o,
    input wire logic [bdp_pkg::BDP_PORT_W-1:0] pin_oe_o
);
    // decoded request kinds
    wire logic dat = avs_address_i == bdp_pkg::BDP_DATA_ADDR;
    wire logic dir = avs_address_i == bdp_pkg::BDP_DIR_ADDR;
    wire logic rq = avs_waitrequest_o && (avs_read_i || avs_write_i);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // data write: taken, then one sampling cycle still waiting
    sequence s_dwr;
        rq && avs_write_i && dat ##1 avs_waitrequest_o;
    endsequence
    chk_dwr_wait: assert property (s_dwr |=> !avs_waitrequest_o ##1
        avs_waitrequest_o) else $error("data write answer timing wrong");
    chk_dwr_latch: assert property (s_dwr ##1 avs_byteenable_i[0] |=>
        pin_o == $past(avs_writedata_i[7:0]))
        else $error("latch not loaded by write");
    chk_fast_ans: assert property (rq && !(avs_write_i && dat) |=>
        !avs_waitrequest_o) else $error("access not answered in time");
    chk_wait_pulse: assert property (!avs_waitrequest_o |=>
        avs_waitrequest_o) else $error("waitrequest low too long");
    chk_dir_oe: assert property (rq && avs_write_i && dir &&
        avs_byteenable_i[0] |=> pin_oe_o == ~$past(avs_writedata_i[7:0]))
        else $error("enables do not follow direction");
    chk_dir_read: assert property (rq && avs_read_i && dir |=>
        avs_readdata_o == {24'h000000, ~pin_oe_o})
        else $error("direction read wrong");
    // held pins must come back through the synchroniser unchanged
    chk_pin_read: assert property (rq && avs_read_i && dat &&
        $stable(pin_i) && pin_i == $past(pin_i, 2) && pin_i == $past(pin_i, 3)
        |=> avs_readdata_o == {24'h000000, $past(pin_i)})
        else $error("data read not pin levels");
    chk_hole_zero: assert property (rq && avs_read_i && !dat && !dir
        |=> avs_readdata_o == 32'h00000000)
        else $error("unmapped read not zero");
    chk_latch_hold: assert property (!por_i && !$past(por_i) &&
        $changed(pin_o) |-> $past(!avs_waitrequest_o && avs_write_i && dat))
        else $error("latch changed without write");
endmodule

bind bdp_port bdp_port_checker u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .por_i(por_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o));

`default_nettype wire

/* File: dv/bdp_pins_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------
// external pin circuitry
// ------------------------------------------------
module bdp_pins_model (
    // clock
    input wire logic clock_i,
    // device side and outside drivers
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] ext_i,
    input wire logic [7:0] ext_en_i,
    // resolved wire levels
    output logic [7:0] lvl_o
);
    logic [7:0] last = 8'h00;
    // no pull: an undriven line shows the inverse of its last driven level,
    // held steady so a floating input reads the same on every sample
    always @(posedge clock_i) begin
        for (int i = 0; i < 8; i++) begin
            if (oe_i[i] || ext_en_i[i]) begin
                last[i] <= lvl_o[i];
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl_o[i] = oe_i[i] ? drv_i[i] : (ext_en_i[i] ? ext_i[i] : ~last[i]);
        end
    end
endmodule

`default_nettype wire

/* File: dv/bdp_port_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------
// port bench
// ------------------------------------------------
module bdp_port_tb_top;
    localparam logic [bdp_pkg::BDP_ADDR_W-1:0] DA = bdp_pkg::BDP_DATA_ADDR;
    localparam logic [bdp_pkg::BDP_ADDR_W-1:0] DR = bdp_pkg::BDP_DIR_ADDR;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic por_i = 1'b1;
    logic [bdp_pkg::BDP_ADDR_W-1:0] adr = DA;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] be = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] got;
    logic [7:0] ext = 8'ha5;
    logic [7:0] ext_en = 8'hff;
    wire logic [31:0] rdat;
    wire logic wt;
    wire logic [7:0] lvl;
    wire logic [7:0] pdrv;
    wire logic [7:0] poe;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;

    // 10 MHz clock
    initial forever #50 clock_i = ~clock_i;

    bdp_port DUT (.clock_i(clock_i), .rst_i(rst_i), .por_i(por_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_byteenable_i(be), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .pin_i(lvl), .pin_o(pdrv), .pin_oe_o(poe));
    bdp_pins_model u_pins (.clock_i(clock_i), .drv_i(pdrv), .oe_i(poe),
        .ext_i(ext), .ext_en_i(ext_en), .lvl_o(lvl));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one access; an idle edge after release keeps strobes single-driven
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
        input logic [3:0] b);
        adr <= a;
        wd <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        do @(posedge clock_i); while (wt !== 1'b0);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd_chk(input string nm, input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(nm, e, got);
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        chk("oe", 32'h0, poe);
        chk("latch", 32'h0, pdrv);
        rd_chk("dir", DR, 32'hff);
        rd_chk("data", DA, 32'ha5);
        rd_chk("hole", 10'h000, 32'h0);
        bus(1'b1, DA, 32'h3c, 4'h1);
        chk("latch", 32'h3c, pdrv);
        rd_chk("data", DA, 32'ha5);
        // outside drives the low nibble, which stays input below
        ext_en <= 8'h0f;
        bus(1'b1, DR, 32'h0f, 4'h1);
        chk("oe", 32'hf0, poe);
        repeat (3) @(posedge clock_i);
        chk("pins", 32'h35, lvl);
        rd_chk("data", DA, 32'h35);
        bus(1'b1, DR, 32'h00, 4'h0);
        bus(1'b1, 10'h000, 32'h00, 4'hf);
        rd_chk("dir", DR, 32'h0f);
        bus(1'b1, DA, 32'h00, 4'h0);
        chk("latch", 32'h35, pdrv);
        bus(1'b1, DR, 32'hff, 4'h1);
        ext_en <= 8'hff;
        for (int n = 0; n < 8; n++) begin
            ext <= 8'h01 << n;
            repeat (3) @(posedge clock_i);
            rd_chk("bit", DA, 32'h1 << n);
        end
        // a plain reset must leave the latch alone
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        chk("latch", 32'h35, pdrv);
        chk("oe", 32'h0, poe);
        rd_chk("dir", DR, 32'hff);
        tally_and_finish();
    end
endmodule

`default_nettype wire
